// ### hbi_pkg.sv
package hbi_pkg;

    // ------------------------------------------------------------
    // Memory and bus geometry
    // ------------------------------------------------------------
    localparam int unsigned RAM_DEPTH  = 1536;       // Working memory words
    localparam int unsigned RAM_AW     = 11;         // Word index width
    localparam int unsigned DATA_W     = 8;          // Host data width
    localparam int unsigned ADDR_W     = 16;         // Host address width
    localparam int unsigned CS_MSB     = 15;         // Top of decoded field
    localparam int unsigned CS_LSB     = 11;         // Bottom of decoded field
    localparam logic [4:0]  CS_MATCH   = 5'h00;      // Decoded field value

    // ------------------------------------------------------------
    // Clock divider and reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  DIV_TERM_2 = 2'h0;       // Toggle every cycle
    localparam logic [1:0]  DIV_TERM_4 = 2'h1;       // Toggle every second cycle
    localparam logic [1:0]  DIV_RST    = 2'h0;       // Divider count at reset
    localparam logic [7:0]  DATA_RST   = 8'h00;      // Read data at reset

    // ------------------------------------------------------------
    // Host access sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HBI_IDLE = 2'b00,                            // Waiting for a strobe
        HBI_WAIT = 2'b01,                            // One memory cycle, host granted if in range
        HBI_DONE = 2'b10                             // Ready shown, wait release
    } hbi_state_e;

    // Host pins after synchronisation
    typedef struct packed {
        logic wr_e;                                  // Write strobe or E clock
        logic rd_dir;                                // Read strobe or direction
        logic cs_n;                                  // External chip select
        logic as;                                    // Address strobe
    } hbi_pins_s;

    // Internal memory request
    typedef struct packed {
        logic              req;                      // Request
        logic              we;                       // Write
        logic [RAM_AW-1:0] addr;                     // Word index
        logic [DATA_W-1:0] wdata;                    // Write data
    } hbi_mreq_s;

endpackage : hbi_pkg

// ### hbi_host_port.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Single-port memory shared by host and sequencer
// - Host wins same-cycle memory contention
// - Asynchronous style ends access with ready
// - Data bus floats while reset applies
// - Float pin low floats every output
// - Factory test pin low selects test mode
// - Write pin: write strobe or E clock
// - Read pin: read strobe or direction
// - Address captured on address strobe
// - Clock output is input divided 2/4
// - Internal select needs address 15..11 zero
// - Multiplexed style latches low address, decodes select
// - Non-multiplexed styles use external chip select
module hbi_host_port
    import hbi_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                sys_rst,
    input  wire logic                bus_family_select,
    input  wire logic                async_mode,
    input  wire logic                divide_by_two,
    input  wire logic                output_float_pin,
    input  wire logic                factory_test_pin,
    input  wire logic                write_or_eclock_in,
    input  wire logic                read_or_direction_in,
    input  wire logic                chip_select_n,
    input  wire logic                address_strobe_in,
    input  wire logic [ADDR_W-1:0]   addr_in,
    input  wire logic [DATA_W-1:0]   data_in,
    output logic      [DATA_W-1:0]   data_out,
    output logic                     data_oe_n,
    output logic                     bus_ready_ack_out,
    output logic                     ready_oe_n,
    output logic                     host_clock_output,
    output logic                     clock_oe_n,
    input  wire logic                irq_event,
    input  wire logic                irq_active_high,
    output logic                     irq_out,
    output logic                     irq_oe_n,
    output logic                     test_mode,
    input  wire logic                seq_req,
    input  wire logic                seq_we,
    input  wire logic [RAM_AW-1:0]   seq_addr,
    input  wire logic [DATA_W-1:0]   seq_wdata,
    output logic                     seq_ack,
    output logic      [DATA_W-1:0]   seq_rdata
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    hbi_pins_s             pins_m_r;                // First stage
    hbi_pins_s             pins_r;                  // Second stage
    hbi_pins_s             pins_d_r;                // Previous sample
    logic [ADDR_W-1:0]     addr_m_r;                // Address first stage
    logic [ADDR_W-1:0]     addr_s_r;                // Address second stage
    logic [DATA_W-1:0]     din_m_r;                 // Data first stage
    logic [DATA_W-1:0]     din_s_r;                 // Data second stage
    logic [2:0]            str_m_r;                 // Strap first stage
    logic [2:0]            str_r;                   // Strap second stage

    // Double sampling of the bus pins and the float, test and divide straps
    always_ff @(posedge clk_sys) begin
        pins_m_r <= '{write_or_eclock_in, read_or_direction_in, chip_select_n,
                      address_strobe_in};
        pins_r   <= pins_m_r;
        pins_d_r <= pins_r;
        addr_m_r <= addr_in;
        addr_s_r <= addr_m_r;
        din_m_r  <= data_in;
        din_s_r  <= din_m_r;
        str_m_r  <= {output_float_pin, factory_test_pin, divide_by_two};
        str_r    <= str_m_r;
    end

    logic float_n;                                  // Low floats all outputs
    assign float_n   = str_r[2];
    assign test_mode = ~str_r[1];

    // ------------------------------------------------------------
    // Style decode
    // ------------------------------------------------------------
    logic e_style;                                  // E clock with direction
    logic a_fall;                                   // Strobe falling edge
    logic a_rise;                                   // Strobe rising edge
    assign e_style = bus_family_select;
    assign a_fall  = pins_d_r.as & ~pins_r.as;
    assign a_rise  = ~pins_d_r.as & pins_r.as;

    // Decode of the high address field, used once for the select
    function automatic logic hi_zero(input logic [ADDR_W-1:0] a);
        hi_zero = (a[CS_MSB:CS_LSB] == CS_MATCH);
    endfunction : hi_zero

    // ------------------------------------------------------------
    // Address capture
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] addr_lat_r;                  // Latched address

    // Capture on strobe fall (multiplexed) or rise (non-muxed)
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            addr_lat_r <= '0;
        end else if (async_mode ? a_rise : a_fall) begin
            addr_lat_r <= addr_s_r;
        end
    end

    // ------------------------------------------------------------
    // Access detection
    // ------------------------------------------------------------
    logic sel;                                      // Device selected
    logic rd_act;                                   // Read in progress
    logic wr_act;                                   // Write in progress
    logic [ADDR_W-1:0] cur_addr;                    // Address of access

    assign cur_addr = async_mode ? addr_s_r : addr_lat_r;
    // Internal decode only in the multiplexed style
    assign sel = async_mode ? ~pins_r.cs_n
                            : hi_zero(addr_lat_r);
    // Strobe meaning depends on the style
    assign rd_act = sel & (e_style ? (pins_r.wr_e & pins_r.rd_dir)
                                   : ~pins_r.rd_dir);
    assign wr_act = sel & (e_style ? (pins_r.wr_e & ~pins_r.rd_dir)
                                   : ~pins_r.wr_e);

    // ------------------------------------------------------------
    // Host sequencer
    // ------------------------------------------------------------
    hbi_state_e  st_r;                              // State
    hbi_state_e  st_nxt;                            // Next state
    hbi_mreq_s   host_req;                          // Host memory request
    logic        host_gnt;                          // Host granted
    logic        in_ram;                            // Address inside memory

    assign in_ram = (cur_addr[RAM_AW-1:0] < RAM_AW'(RAM_DEPTH));
    assign host_req.req   = (st_r == HBI_WAIT) & in_ram;
    assign host_req.we    = wr_act;
    assign host_req.addr  = cur_addr[RAM_AW-1:0];
    assign host_req.wdata = din_s_r;
    assign host_gnt       = host_req.req;

    // Next-state selection
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            HBI_IDLE: begin
                if (rd_act | wr_act) begin
                    st_nxt = HBI_WAIT;
                end
            end
            HBI_WAIT: begin
                // Out-of-range access finishes without touching memory
                st_nxt = HBI_DONE;
            end
            HBI_DONE: begin
                if (!(rd_act | wr_act)) begin
                    st_nxt = HBI_IDLE;
                end
            end
            default: begin
                st_nxt = HBI_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= HBI_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Shared memory and arbiter
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ram_r [RAM_DEPTH];           // Single-port array
    logic [DATA_W-1:0] rdata_r;                     // Host read data
    logic              seq_gnt;                     // Sequencer granted
    logic [RAM_AW-1:0] port_addr;                   // Shared address

    assign seq_gnt   = seq_req & ~host_gnt;
    assign port_addr = host_gnt ? host_req.addr : seq_addr;

    // One port: one write per cycle from the granted side
    always_ff @(posedge clk_sys) begin
        if (host_gnt ? host_req.we : (seq_gnt & seq_we)) begin
            ram_r[port_addr] <= host_gnt ? host_req.wdata : seq_wdata;
        end
    end

    // Read data for each side
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_r   <= DATA_RST;
            seq_rdata <= DATA_RST;
            seq_ack   <= 1'b0;
        end else begin
            seq_ack <= seq_gnt;
            if (host_gnt) begin
                rdata_r <= ram_r[port_addr];
            end else if (st_r == HBI_WAIT) begin
                rdata_r <= DATA_RST;
            end
            if (seq_gnt) begin
                seq_rdata <= ram_r[port_addr];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    assign data_out  = rdata_r;
    // Drive only during a finished read, never in reset or float
    assign data_oe_n = sys_rst | ~float_n
                       | ~(rd_act & (st_r == HBI_DONE));
    assign bus_ready_ack_out = ~(st_r == HBI_DONE);
    assign ready_oe_n = ~float_n | ~async_mode;
    assign irq_out    = irq_event ~^ irq_active_high;
    assign irq_oe_n   = ~float_n | sys_rst;
    assign clock_oe_n = ~float_n;

    // ------------------------------------------------------------
    // Clock divider
    // ------------------------------------------------------------
    logic [1:0] div_r;                              // Divider count
    logic       clk_q_r;                            // Divided clock level

    // Toggle output at the selected terminal count
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            div_r   <= DIV_RST;
            clk_q_r <= 1'b0;
        end else if (div_r >= (str_r[0] ? DIV_TERM_2 : DIV_TERM_4)) begin
            div_r   <= DIV_RST;
            clk_q_r <= ~clk_q_r;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end
    assign host_clock_output = clk_q_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_host_priority: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (host_gnt && seq_req) |-> !seq_gnt) else $error("sequencer not held off");
    chk_data_float_rst: assert property (@(posedge clk_sys)
        sys_rst |-> data_oe_n) else $error("data driven in reset");
    chk_float_all: assert property (@(posedge clk_sys)
        !float_n |-> (data_oe_n && ready_oe_n && irq_oe_n && clock_oe_n))
        else $error("output driven while floated");
    chk_ready_after: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_r == HBI_IDLE && (rd_act || wr_act)) |=> ##1 !bus_ready_ack_out)
        else $error("ready not given");
    chk_div_toggle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (str_r[0] && $stable(str_r[0]) && div_r == DIV_RST)
        |=> host_clock_output != $past(host_clock_output))
        else $error("divide by two failed");
    chk_ext_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (async_mode && pins_r.cs_n) |-> !sel) else $error("select without pin");
    chk_int_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (!async_mode && addr_lat_r[CS_MSB:CS_LSB] != CS_MATCH) |-> !sel)
        else $error("decode outside window");
    chk_test_mode: assert property (@(posedge clk_sys)
        test_mode == !str_r[1]) else $error("test mode mismatch");

endmodule : hbi_host_port
`default_nettype wire

// ### hbi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// Host bus master model
// --------------------
module hbi_host_model
    import hbi_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              family,
    input  wire logic              async_sel,
    input  wire logic [DATA_W-1:0] data_out,
    input  wire logic              bus_ready_ack_out,
    output logic                   wr_e,
    output logic                   rd_dir,
    output logic                   cs_n,
    output logic                   as,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] data
);
    // Idle pins at start, strobe style
    initial begin
        {wr_e, rd_dir, cs_n, as} = 4'hE;
        addr = '1;
        data = '1;
    end
    // Strobes inactive for the given style
    task automatic park(input logic f);
        wr_e   <= ~f;
        rd_dir <= 1'b1;
        cs_n   <= 1'b1;
        as     <= 1'b0;
    endtask : park
    // One byte access, ready awaited under a bound
    task automatic access(input logic we, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] wd,
                          output logic [DATA_W-1:0] rd, output logic rdy);
        rdy = 1'b0;
        @(posedge clk_sys);
        addr   <= a;
        data   <= wd;
        as     <= 1'b1;
        cs_n   <= ~async_sel;
        rd_dir <= family ? ~we : 1'b1;
        repeat (3) @(posedge clk_sys);
        as <= 1'b0;
        repeat (2) @(posedge clk_sys);
        // Multiplexed low lines now carry data
        if (!async_sel) addr[7:0] <= wd;
        if (family) wr_e <= 1'b1;
        else if (we) wr_e <= 1'b0;
        else rd_dir <= 1'b0;
        for (int n = 0; n < 12 && !rdy; n++) begin
            @(posedge clk_sys);
            #1;
            rdy = (bus_ready_ack_out === 1'b0);
        end
        rd = data_out;
        @(posedge clk_sys);
        park(family);
        // Released lines show the inverse, never the old value
        addr <= ~a;
        data <= ~wd;
        repeat (4) @(posedge clk_sys);
    endtask : access
endmodule : hbi_host_model
`default_nettype wire

// ### host_bus_interface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------
// Host port bench
// --------------------
module host_bus_interface_tb_top import hbi_pkg::*;;
    logic              clk_sys = 1'b0, sys_rst = 1'b1; // Clock, reset
    logic              fam = 1'b0, asy = 1'b0, div2 = 1'b1; // Straps
    logic              flt_n = 1'b1, tst_n = 1'b1; // Test pins
    logic              irq_ev = 1'b0, irq_ah = 1'b1; // Interrupt source
    hbi_mreq_s         sreq = '0; // Sequencer request
    logic              wr_e, rd_dir, cs_n, as_s, doe_n, rdy, roe_n;
    logic              hclk, coe_n, irq, ioe_n, tmode, sack, ok;
    logic [ADDR_W-1:0] haddr;
    logic [DATA_W-1:0] hdata, dout, srd, q, q2, d;
    logic [RAM_AW-1:0] a;
    logic [DATA_W-1:0] ref_mem [int]; // Behavioural memory
    int                n_mismatch = 0, n_compared = 0, seed = 99450, cyc = 0;
    // Shared data bus level
    wire logic [DATA_W-1:0] dbus = doe_n ? hdata : dout;
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    hbi_host_model host (.clk_sys(clk_sys), .family(fam), .async_sel(asy), .data_out(dout),
        .bus_ready_ack_out(rdy), .wr_e(wr_e), .rd_dir(rd_dir), .cs_n(cs_n), .as(as_s),
        .addr(haddr), .data(hdata));
    hbi_host_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_family_select(fam),
        .async_mode(asy), .divide_by_two(div2), .output_float_pin(flt_n),
        .factory_test_pin(tst_n), .write_or_eclock_in(wr_e), .read_or_direction_in(rd_dir),
        .chip_select_n(cs_n), .address_strobe_in(as_s), .addr_in(haddr), .data_in(dbus),
        .data_out(dout), .data_oe_n(doe_n), .bus_ready_ack_out(rdy), .ready_oe_n(roe_n),
        .host_clock_output(hclk), .clock_oe_n(coe_n), .irq_event(irq_ev),
        .irq_active_high(irq_ah), .irq_out(irq), .irq_oe_n(ioe_n), .test_mode(tmode),
        .seq_req(sreq.req), .seq_we(sreq.we), .seq_addr(sreq.addr), .seq_wdata(sreq.wdata),
        .seq_ack(sack), .seq_rdata(srd));
    // Byte and bit comparisons
    task automatic cmp_byte(input logic [DATA_W-1:0] g, e, input string m);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input logic g, e, input string m);
        cmp_byte({7'h00, g}, {7'h00, e}, m);
    endtask : cmp_bit
    // Sequencer access, request held until acknowledged
    task automatic seq_op(input logic w, input logic [RAM_AW-1:0] x,
                          input logic [DATA_W-1:0] v, output logic [DATA_W-1:0] r);
        @(posedge clk_sys);
        sreq <= '{req: 1'b1, we: w, addr: x, wdata: v};
        for (int n = 0; n < 40 && sack !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        cmp_bit(sack, 1'b1, "seq ack");
        r = srd;
        sreq.req <= 1'b0;
        if (w) ref_mem[x] = v;
        // Let the trailing acknowledge pass before another request
        @(posedge clk_sys);
        #1;
    endtask : seq_op
    // Clock output period in input cycles
    task automatic div_chk(input logic s, input logic [DATA_W-1:0] e);
        realtime t;
        @(posedge clk_sys);
        div2 <= s;
        repeat (8) @(posedge clk_sys);
        @(posedge hclk);
        t = $realtime;
        @(posedge hclk);
        cmp_byte(DATA_W'(int'(($realtime - t) / 25.0)), e, "clock divide");
    endtask : div_chk
    // Closing report
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    // Hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("[FAIL] %0t run did not finish", $time);
            give_verdict();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        cmp_bit(doe_n, 1'b1, "data float in reset");
        cmp_bit(hclk, 1'b0, "clock idle in reset");
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        div_chk(1'b1, 8'h02);
        div_chk(1'b0, 8'h04);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {irq_ah, irq_ev} <= 2'(i);
            repeat (4) @(posedge clk_sys);
            #1;
            cmp_bit(irq, i[1] ? i[0] : !i[0], "irq level");
            cmp_bit(ioe_n, 1'b0, "irq driven");
        end
        @(posedge clk_sys);
        {flt_n, tst_n} <= 2'h0;
        repeat (4) @(posedge clk_sys);
        #1;
        cmp_bit(&{doe_n, roe_n, coe_n, ioe_n}, 1'b1, "all float");
        cmp_bit(tmode, 1'b1, "test mode on");
        @(posedge clk_sys);
        {flt_n, tst_n} <= 2'h3;
        repeat (4) @(posedge clk_sys);
        #1;
        cmp_bit(tmode, 1'b0, "test mode off");
        cmp_bit(coe_n, 1'b0, "clock driven");
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            {fam, asy} <= 2'(m);
            host.park(m[1]);
            repeat (4) @(posedge clk_sys);
            for (int k = 0; k < 3; k++) begin
                a = RAM_AW'($unsigned($random(seed)) % RAM_DEPTH);
                d = DATA_W'($random(seed));
                host.access(1'b1, {5'h00, a}, d, q, ok);
                ref_mem[a] = d;
                cmp_bit(ok | !m[0], 1'b1, "ready on write");
                host.access(1'b0, {5'h00, a}, 8'h00, q, ok);
                cmp_byte(q, ref_mem[a], "host read");
                seq_op(1'b0, a, 8'h00, q);
                cmp_byte(q, ref_mem[a], "seq sees host");
                seq_op(1'b1, a, ~d, q);
                host.access(1'b0, {5'h00, a}, 8'h00, q, ok);
                cmp_byte(q, ref_mem[a], "host sees seq");
            end
            cmp_bit(roe_n, !m[0], "ready drive");
            for (int b = 0; b < 5 && !m[0]; b++) begin
                host.access(1'b1, {5'(1 << b), a}, d, q, ok);
                seq_op(1'b0, a, 8'h00, q);
                cmp_byte(q, ref_mem[a], "outside window");
            end
            host.access(1'b1, 16'h0600 + 16'(m), 8'hA5, q, ok);
            host.access(1'b0, 16'h0600 + 16'(m), 8'h00, q, ok);
            cmp_byte(q, 8'h00, "beyond memory");
            fork
                host.access(1'b1, {5'h00, a}, d, q, ok);
                repeat (6) seq_op(1'b1, a ^ 11'h001, ~d, q2);
            join
            ref_mem[a] = d;
            cmp_bit(ok | !m[0], 1'b1, "host served first");
            host.access(1'b0, {5'h00, a ^ 11'h001}, 8'h00, q, ok);
            cmp_byte(q, ~d, "contended seq data");
            seq_op(1'b0, a, 8'h00, q);
            cmp_byte(q, d, "contended host data");
        end
        give_verdict();
    end
endmodule : host_bus_interface_tb_top
`default_nettype wire
